// [pkg/opp_perf_pkg.sv]
/*
  Shared constants, register map and types for the opportunistic
  performance control block and its per-processor counter bank.
  Assumes one model-register request port per package, addressed by
  register number, and a 250 MHz ref_clk for all logic.
*/
package opp_perf_pkg;

  // ---------------------------------------------------------------
  // register numbers
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_FIXED_RATE  = 32'h0000_00E7;
  localparam logic [31:0] ADDR_ACTUAL_PERF = 32'h0000_00E8;
  localparam logic [31:0] ADDR_PERF_STATUS = 32'h0000_0198;
  localparam logic [31:0] ADDR_PERF_CTL    = 32'h0000_0199;
  localparam logic [31:0] ADDR_CORE_TICK   = 32'h0000_030A;
  localparam logic [31:0] ADDR_REF_TICK    = 32'h0000_030B;
  localparam logic [31:0] ADDR_MISC_ENABLE = 32'h0000_0400;
  localparam logic [31:0] ADDR_PLAT_INFO   = 32'h0000_0401;
  localparam logic [31:0] ADDR_TIMESTAMP   = 32'h0000_0402;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          MISC_OPP_DISABLE_BIT = 38;
  localparam int          MISC_FREEZE_MGMT_BIT = 12;
  localparam int          CTL_HOLD_BIT         = 32;
  localparam int          OP_POINT_W           = 16;
  localparam int          PLAT_RATIO_LSB       = 8;
  localparam int          PLAT_RATIO_MSB       = 15;
  localparam logic        FREEZE_RESET         = 1'h0;
  localparam logic        HOLD_RESET           = 1'h0;
  localparam logic [15:0] TARGET_RESET         = 16'h0000;
  localparam logic [7:0]  BASE_RATIO_DEF       = 8'h10;

  // ---------------------------------------------------------------
  // counter read selectors and feature query
  // ---------------------------------------------------------------
  localparam logic [31:0] PMC_SEL_CORE        = 32'h4000_0001;
  localparam logic [31:0] PMC_SEL_REF         = 32'h4000_0002;
  localparam logic [31:0] QUERY_LEAF_POWER    = 32'h0000_0006;
  localparam int          QUERY_EAX_BOOST_BIT = 1;
  localparam int          QUERY_ECX_FB_BIT    = 0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          BASE_CLK_KHZ   = 133330; // base clock, 133.33 MHz
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;   // fill of the 3-flop strap sync

  typedef enum logic [1:0] {
    CNT_ACTUAL = 2'b00,
    CNT_FIXED  = 2'b01,
    CNT_CORE   = 2'b10,
    CNT_REF    = 2'b11
  } cnt_sel_t;

  typedef enum logic [3:0] {
    RK_NONE   = 4'b0000,
    RK_STATUS = 4'b0001,
    RK_CTL    = 4'b0010,
    RK_ACTUAL = 4'b0011,
    RK_FIXED  = 4'b0100,
    RK_CORE   = 4'b0101,
    RK_REF    = 4'b0110,
    RK_MISC   = 4'b0111,
    RK_PLAT   = 4'b1000,
    RK_TSC    = 4'b1001
  } reg_kind_t;

  typedef enum logic {
    PH_STRAP = 1'b0,
    PH_RUN   = 1'b1
  } phase_t;

  // register number to register kind, shared by write and read paths
  function automatic reg_kind_t reg_kind(input logic [31:0] addr);
    reg_kind_t k;
    k = RK_NONE;
    unique case (addr)
      ADDR_PERF_STATUS: k = RK_STATUS;
      ADDR_PERF_CTL:    k = RK_CTL;
      ADDR_ACTUAL_PERF: k = RK_ACTUAL;
      ADDR_FIXED_RATE:  k = RK_FIXED;
      ADDR_CORE_TICK:   k = RK_CORE;
      ADDR_REF_TICK:    k = RK_REF;
      ADDR_MISC_ENABLE: k = RK_MISC;
      ADDR_PLAT_INFO:   k = RK_PLAT;
      ADDR_TIMESTAMP:   k = RK_TSC;
      default:          k = RK_NONE;
    endcase
    return k;
  endfunction : reg_kind

endpackage : opp_perf_pkg

// [pkg/perf_pair_if.sv]
/*
  Carrier between the control block and one per-processor counter bank.
  Assumes both ends run on the same ref_clk.
*/
`timescale 1ns/1ps
interface perf_pair_if;
  import opp_perf_pkg::*;
  logic        count_en;   // processor active and not frozen
  logic        core_tick;  // one unhalted core clock tick
  logic        ref_tick;   // one unhalted reference tick
  logic        wr_en;      // software write to a counter
  cnt_sel_t    wr_sel;     // which counter is written
  logic [63:0] wdata;      // value written
  logic [63:0] actual;     // actual-performance count
  logic [63:0] fixed;      // fixed-rate count
  logic [63:0] core_cnt;   // unhalted core ticks
  logic [63:0] ref_cnt;    // unhalted reference ticks

  modport ctrl (output count_en, core_tick, ref_tick, wr_en, wr_sel, wdata,
                input  actual, fixed, core_cnt, ref_cnt);
  modport bank (input  count_en, core_tick, ref_tick, wr_en, wr_sel, wdata,
                output actual, fixed, core_cnt, ref_cnt);
endinterface : perf_pair_if

// [rtl/perf_counter_bank.sv]
/*
  Four 64-bit performance counters of one logical processor.
  Assumes the controller gates count_en for idle and freeze conditions.
*/
`timescale 1ns/1ps
module perf_counter_bank
  import opp_perf_pkg::*;
(
  input  wire logic  ref_clk,  // reference clock
  input  wire logic  reset_n,  // async reset, active low
  perf_pair_if.bank  pif       // control and counts
);

  typedef struct packed {
    logic [63:0] actual;
    logic [63:0] fixed;
    logic [63:0] core_cnt;
    logic [63:0] ref_cnt;
  } bank_state_t;

  bank_state_t st_reg;
  bank_state_t st_next;
  logic        inc_a;
  logic        inc_f;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // a software write wins over a count in the same cycle
  always_comb begin
    st_next = st_reg;
    inc_a   = pif.count_en & pif.core_tick;
    inc_f   = pif.count_en & pif.ref_tick;
    // both clear together so the ratio stays meaningful after a wrap
    if ((inc_a && (&st_reg.actual)) || (inc_f && (&st_reg.fixed))) begin
      st_next.actual = 64'h0;
      st_next.fixed  = 64'h0;
    end else begin
      st_next.actual = st_reg.actual + 64'(inc_a);
      st_next.fixed  = st_reg.fixed + 64'(inc_f);
    end
    st_next.core_cnt = st_reg.core_cnt + 64'(inc_a);
    st_next.ref_cnt  = st_reg.ref_cnt + 64'(inc_f);
    if (pif.wr_en) begin
      unique case (pif.wr_sel)
        CNT_ACTUAL: st_next.actual   = pif.wdata;
        CNT_FIXED:  st_next.fixed    = pif.wdata;
        CNT_CORE:   st_next.core_cnt = pif.wdata;
        CNT_REF:    st_next.ref_cnt  = pif.wdata;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pif.actual   = st_reg.actual;
  assign pif.fixed    = st_reg.fixed;
  assign pif.core_cnt = st_reg.core_cnt;
  assign pif.ref_cnt  = st_reg.ref_cnt;

endmodule : perf_counter_bank

// [rtl/opp_perf_control.sv]
/*
  Opportunistic performance control: package enable, per-processor hold,
  boost eligibility, feature query, counter reads and timestamp.
  Assumes requests come from same-clock logic, one per cycle per port;
  only boost_capable is a pin strap and is synchronised.
*/
`timescale 1ns/1ps
module opp_perf_control
  import opp_perf_pkg::*;
#(
  parameter int         NUM_LP     = 2,              // logical processors
  parameter logic [7:0] BASE_RATIO = BASE_RATIO_DEF  // timestamp to base clock
) (
  input  wire logic                                    ref_clk,          // 250 MHz
  input  wire logic                                    reset_n,          // async, low
  input  wire logic                                    boost_capable,    // part strap
  input  wire logic                                    msr_req,          // register access
  input  wire logic                                    msr_write,        // 1 write, 0 read
  input  wire logic [$clog2(NUM_LP)-1:0]               msr_lp,           // target processor
  input  wire logic [31:0]                             msr_addr,         // register number
  input  wire logic [63:0]                             msr_wdata,        // write data
  output      logic                                    msr_ack,          // access done
  output      logic [63:0]                             msr_rdata,        // read data
  output      logic                                    msr_fault,        // bad access
  input  wire logic                                    pmc_req,          // counter read
  input  wire logic [$clog2(NUM_LP)-1:0]               pmc_lp,           // processor
  input  wire logic [31:0]                             pmc_sel,          // selector
  output      logic                                    pmc_ack,          // read done
  output      logic [63:0]                             pmc_data,         // counter value
  output      logic                                    pmc_fault,        // bad selector
  input  wire logic                                    query_req,        // feature query
  input  wire logic [31:0]                             query_leaf,       // leaf number
  output      logic                                    query_ack,        // query done
  output      logic [31:0]                             query_eax,        // first result
  output      logic [31:0]                             query_ecx,        // third result
  input  wire logic [NUM_LP-1:0]                       lp_active,        // processor in C0
  input  wire logic [NUM_LP-1:0]                       core_tick,        // core clock tick
  input  wire logic [NUM_LP-1:0]                       ref_tick,         // reference tick
  input  wire logic                                    base_tick,        // base clock tick
  input  wire logic                                    mgmt_mode_active, // handler running
  input  wire logic                                    headroom_ok,      // thermal headroom
  input  wire logic [NUM_LP-1:0]                       criteria_ok,      // internal criteria
  input  wire logic [NUM_LP-1:0][OP_POINT_W-1:0]       current_op_point, // live op point
  output      logic [NUM_LP-1:0]                       boost_eligible,   // may boost
  output      logic [NUM_LP-1:0]                       boost_engaged,    // boosting now
  output      logic [NUM_LP-1:0][OP_POINT_W-1:0]       target_op_point   // requested point
);

  localparam int LPW = $clog2(NUM_LP);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    phase_t                          phase;
    logic [1:0]                      settle;
    logic [2:0]                      strap_sync;
    logic                            capable;
    logic                            opp_disable;
    logic                            freeze_en;
    logic [NUM_LP-1:0]               hold;
    logic [NUM_LP-1:0][OP_POINT_W-1:0] target;
    logic [NUM_LP-1:0][OP_POINT_W-1:0] status;
    logic [63:0]                     tsc;
    logic [NUM_LP-1:0]               eligible;
    logic [NUM_LP-1:0]               engaged;
    logic                            msr_ack;
    logic [63:0]                     msr_rdata;
    logic                            msr_fault;
    logic                            pmc_ack;
    logic [63:0]                     pmc_data;
    logic                            pmc_fault;
    logic                            query_ack;
    logic [31:0]                     query_eax;
    logic [31:0]                     query_ecx;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  // per-processor counter values gathered from the banks
  logic [NUM_LP-1:0][63:0] lp_actual;
  logic [NUM_LP-1:0][63:0] lp_fixed;
  logic [NUM_LP-1:0][63:0] lp_core;
  logic [NUM_LP-1:0][63:0] lp_ref;
  logic                    counting_ok;
  logic                    lp_ok;
  logic                    pmc_lp_ok;
  reg_kind_t               kind;

  assign kind        = reg_kind(msr_addr);
  assign lp_ok       = (32'(msr_lp) < NUM_LP);
  assign pmc_lp_ok   = (32'(pmc_lp) < NUM_LP);
  // freezing only applies while the option is on and the handler runs
  assign counting_ok = ~(st_reg.freeze_en & mgmt_mode_active);

  // ---------------------------------------------------------------
  // counter banks, one per logical processor
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_LP; g++) begin : g_lp
    perf_pair_if pif ();

    assign pif.count_en  = lp_active[g] & counting_ok;
    assign pif.core_tick = core_tick[g];
    assign pif.ref_tick  = ref_tick[g];
    assign pif.wdata     = msr_wdata;
    // counter writes land on the same edge as the access is acknowledged
    assign pif.wr_en     = msr_req & msr_write & (32'(msr_lp) == g) &
                           ((kind == RK_ACTUAL) | (kind == RK_FIXED) |
                            (kind == RK_CORE) | (kind == RK_REF));
    always_comb begin
      unique case (kind)
        RK_FIXED: pif.wr_sel = CNT_FIXED;
        RK_CORE:  pif.wr_sel = CNT_CORE;
        RK_REF:   pif.wr_sel = CNT_REF;
        default:  pif.wr_sel = CNT_ACTUAL;
      endcase
    end

    assign lp_actual[g] = pif.actual;
    assign lp_fixed[g]  = pif.fixed;
    assign lp_core[g]   = pif.core_cnt;
    assign lp_ref[g]    = pif.ref_cnt;

    perf_counter_bank u_bank (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .pif     (pif.bank)
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.msr_ack   = 1'b0;
    st_next.msr_fault = 1'b0;
    st_next.pmc_ack   = 1'b0;
    st_next.pmc_fault = 1'b0;
    st_next.query_ack = 1'b0;

    // strap sync; only the second and third stages are compared
    st_next.strap_sync = {st_reg.strap_sync[1:0], boost_capable};

    unique case (st_reg.phase)
      PH_STRAP: begin
        if (st_reg.settle != STRAP_SETTLE) begin
          st_next.settle = st_reg.settle + 2'h1;
        end else if (st_reg.strap_sync[2] == st_reg.strap_sync[1]) begin
          // disable bit comes up as 1 only on a capable part
          st_next.capable     = st_reg.strap_sync[2];
          st_next.opp_disable = st_reg.strap_sync[2];
          st_next.phase       = PH_RUN;
        end
      end
      PH_RUN: begin
        st_next.settle = st_reg.settle;
      end
    endcase

    // timestamp advances every base tick, also while processors idle
    if (base_tick) begin
      st_next.tsc = st_reg.tsc + 64'(BASE_RATIO);
    end

    // live operating point, kept apart from the hold bit
    st_next.status = current_op_point;

    // model register access
    if (msr_req) begin
      st_next.msr_ack   = 1'b1;
      st_next.msr_rdata = 64'h0;
      if (!lp_ok || kind == RK_NONE) begin
        st_next.msr_fault = 1'b1;
      end else if (msr_write) begin
        unique case (kind)
          RK_CTL: begin
            // whole register is taken, so software must read-modify-write
            st_next.target[msr_lp] = msr_wdata[OP_POINT_W-1:0];
            st_next.hold[msr_lp]   = msr_wdata[CTL_HOLD_BIT];
          end
          RK_MISC: begin
            // one package copy, whichever processor writes it
            st_next.opp_disable = msr_wdata[MISC_OPP_DISABLE_BIT];
            st_next.freeze_en   = msr_wdata[MISC_FREEZE_MGMT_BIT];
          end
          RK_ACTUAL, RK_FIXED, RK_CORE, RK_REF: begin
            st_next.msr_fault = 1'b0;
          end
          default: begin
            st_next.msr_fault = 1'b1; // read-only register
          end
        endcase
      end else begin
        unique case (kind)
          RK_STATUS: st_next.msr_rdata[OP_POINT_W-1:0] = st_reg.status[msr_lp];
          RK_CTL: begin
            st_next.msr_rdata[OP_POINT_W-1:0] = st_reg.target[msr_lp];
            st_next.msr_rdata[CTL_HOLD_BIT]   = st_reg.hold[msr_lp];
          end
          RK_ACTUAL: st_next.msr_rdata = lp_actual[msr_lp];
          RK_FIXED:  st_next.msr_rdata = lp_fixed[msr_lp];
          RK_CORE:   st_next.msr_rdata = lp_core[msr_lp];
          RK_REF:    st_next.msr_rdata = lp_ref[msr_lp];
          RK_MISC: begin
            st_next.msr_rdata[MISC_OPP_DISABLE_BIT] = st_reg.opp_disable;
            st_next.msr_rdata[MISC_FREEZE_MGMT_BIT] = st_reg.freeze_en;
          end
          RK_PLAT:   st_next.msr_rdata[PLAT_RATIO_MSB:PLAT_RATIO_LSB] = BASE_RATIO;
          RK_TSC:    st_next.msr_rdata = st_reg.tsc;
          default:   st_next.msr_fault = 1'b1;
        endcase
      end
    end

    // counter read instruction path
    if (pmc_req) begin
      st_next.pmc_ack  = 1'b1;
      st_next.pmc_data = 64'h0;
      if (!pmc_lp_ok) begin
        st_next.pmc_fault = 1'b1;
      end else if (pmc_sel == PMC_SEL_CORE) begin
        st_next.pmc_data = lp_core[pmc_lp];
      end else if (pmc_sel == PMC_SEL_REF) begin
        st_next.pmc_data = lp_ref[pmc_lp];
      end else begin
        st_next.pmc_fault = 1'b1;
      end
    end

    // feature query, power leaf only; other leaves answer zero
    if (query_req) begin
      st_next.query_ack = 1'b1;
      st_next.query_eax = 32'h0;
      st_next.query_ecx = 32'h0;
      if (query_leaf == QUERY_LEAF_POWER) begin
        st_next.query_eax[QUERY_EAX_BOOST_BIT] = st_reg.capable & ~st_reg.opp_disable;
        st_next.query_ecx[QUERY_ECX_FB_BIT]    = 1'b1;
      end
    end

    // eligibility gates on enable and hold; headroom and criteria_ok decide the rest
    for (int i = 0; i < NUM_LP; i++) begin
      st_next.eligible[i] = (st_reg.phase == PH_RUN) & st_reg.capable &
                            ~st_reg.opp_disable & ~st_reg.hold[i];
      // engaging may take the clock past the maximum qualified point
      st_next.engaged[i]  = st_reg.eligible[i] & headroom_ok & criteria_ok[i];
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // every control bit takes a constant here; the strap is caught later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg           <= '0;
      st_reg.phase     <= PH_STRAP;
      st_reg.freeze_en <= FREEZE_RESET;
      st_reg.hold      <= {NUM_LP{HOLD_RESET}};
      st_reg.target    <= {NUM_LP{TARGET_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  assign msr_ack         = st_reg.msr_ack;
  assign msr_rdata       = st_reg.msr_rdata;
  assign msr_fault       = st_reg.msr_fault;
  assign pmc_ack         = st_reg.pmc_ack;
  assign pmc_data        = st_reg.pmc_data;
  assign pmc_fault       = st_reg.pmc_fault;
  assign query_ack       = st_reg.query_ack;
  assign query_eax       = st_reg.query_eax;
  assign query_ecx       = st_reg.query_ecx;
  assign boost_eligible  = st_reg.eligible;
  assign boost_engaged   = st_reg.engaged;
  assign target_op_point = st_reg.target;

  // base clock rate is carried for software frequency estimates only
  localparam int UNUSED_BASE_KHZ = BASE_CLK_KHZ;

endmodule : opp_perf_control

// [tb/opp_perf_control_asserts.sv]
/* port checker for the opportunistic control block.
   assumes it is bound onto every opp_perf_control instance. */
`timescale 1ns/1ps
module opp_perf_control_asserts
  import opp_perf_pkg::*;
#(parameter int NUM_LP = 2) (
  input wire logic                      ref_clk,        // clock
  input wire logic                      reset_n,        // async low
  input wire logic                      msr_req,        // access
  input wire logic                      msr_write,      // write
  input wire logic [$clog2(NUM_LP)-1:0] msr_lp,         // processor
  input wire logic [31:0]               msr_addr,       // number
  input wire logic [63:0]               msr_wdata,      // data
  input wire logic                      msr_ack,        // done
  input wire logic                      msr_fault,      // refused
  input wire logic                      query_req,      // query
  input wire logic [31:0]               query_leaf,     // leaf
  input wire logic                      query_ack,      // done
  input wire logic [31:0]               query_eax,      // result
  input wire logic                      headroom_ok,    // headroom
  input wire logic [NUM_LP-1:0]         criteria_ok,    // criteria
  input wire logic [NUM_LP-1:0]         boost_eligible, // may boost
  input wire logic [NUM_LP-1:0]         boost_engaged   // boosting
);
  // ------------
  // properties
  // ------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // hold write on processor 0, then eligibility drops one cycle after ack
  sequence s_hold_set;
    msr_req && msr_write && msr_lp == 0 && msr_addr == ADDR_PERF_CTL && msr_wdata[CTL_HOLD_BIT];
  endsequence
  sequence s_drop;
    ##1 !boost_eligible[0];
  endsequence
  property p_hold; s_hold_set |=> s_drop; endproperty
  a_hold: assert property (p_hold) else $error("hold did not stop eligibility");
  property p_ack; msr_req |=> msr_ack; endproperty
  a_ack: assert property (p_ack) else $error("register access not answered");
  property p_status_ro; msr_req && msr_write && msr_addr == ADDR_PERF_STATUS |=> msr_fault; endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write not refused");
  property p_qack; query_req |=> query_ack; endproperty
  a_qack: assert property (p_qack) else $error("query not answered");
  property p_qother; query_req && query_leaf != QUERY_LEAF_POWER |=> query_eax == 32'h0; endproperty
  a_qother: assert property (p_qother) else $error("other leaf not zero");
  property p_qlink; query_ack && boost_eligible[0] |-> query_eax[QUERY_EAX_BOOST_BIT]; endproperty
  a_qlink: assert property (p_qlink) else $error("eligible but query shows off");
  property p_need;
    boost_engaged[0] |-> $past(boost_eligible[0]) && $past(headroom_ok) && $past(criteria_ok[0]);
  endproperty
  a_need: assert property (p_need) else $error("boost without cause");
  property p_on; boost_eligible[0] && headroom_ok && criteria_ok[0] |=> boost_engaged[0]; endproperty
  a_on: assert property (p_on) else $error("boost not engaged");
endmodule : opp_perf_control_asserts
bind opp_perf_control opp_perf_control_asserts #(.NUM_LP(NUM_LP)) i_chk (.ref_clk, .reset_n,
  .msr_req, .msr_write, .msr_lp, .msr_addr, .msr_wdata, .msr_ack, .msr_fault, .query_req,
  .query_leaf, .query_ack, .query_eax, .headroom_ok, .criteria_ok, .boost_eligible, .boost_engaged);

// [tb/test_opp_perf_control.sv]
/* self-checking bench for opp_perf_control, two processors.
   assumes the checker binds itself; all stimulus is local. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module test_opp_perf_control;
  import opp_perf_pkg::*;
  logic ref_clk, reset_n, boost_capable, msr_req, msr_write, pmc_req, query_req, base_tick;
  logic mgmt_mode_active, headroom_ok, msr_ack, msr_fault, pmc_ack, pmc_fault, query_ack, f;
  logic [0:0]       msr_lp, pmc_lp;
  logic [31:0]      msr_addr, pmc_sel, query_leaf, query_eax, query_ecx, seed;
  logic [63:0]      msr_wdata, msr_rdata, pmc_data, rd, a, b, n;
  logic [1:0]       lp_active, core_tick, ref_tick, criteria_ok, boost_eligible, boost_engaged;
  logic [1:0][15:0] current_op_point, target_op_point;
  int               mismatches, n_compared;
  opp_perf_control i_dut (.*);
  // ------------
  // helpers
  // ------------
  always #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // one access; ack lands on the taking edge and is checked 1 ns after it
  task automatic mr(input logic lp, input logic wr, input logic [31:0] ad, input logic [63:0] wd);
    @(posedge ref_clk);
    {msr_req, msr_write, msr_lp, msr_addr, msr_wdata} <= {1'b1, wr, lp, ad, wd};
    @(posedge ref_clk);
    msr_req <= 1'b0;
    #1;
    `CHK(msr_ack, 1'b1)
    rd = msr_rdata;
    f = msr_fault;
  endtask : mr
  task automatic qp(input logic q, input logic [31:0] v);
    @(posedge ref_clk);
    {query_req, pmc_req, query_leaf, pmc_sel} <= {q, !q, v, v};
    @(posedge ref_clk);
    {query_req, pmc_req} <= 2'b00;
    #1;
    `CHK(q ? query_ack : pmc_ack, 1'b1)
    f = pmc_fault;
  endtask : qp
  // ticks are two cycles apart so a read never races a count
  task automatic tk(input int c, input logic [1:0] cr, input logic bt);
    repeat (c) begin
      @(posedge ref_clk);
      {core_tick, ref_tick, base_tick} <= {1'b0, cr[0], 1'b0, cr[1], bt};
      @(posedge ref_clk);
      {core_tick, ref_tick, base_tick} <= 5'h00;
    end
  endtask : tk
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end
  // ------------
  // main sequence
  // ------------
  initial begin
    {ref_clk, reset_n, msr_req, msr_write, pmc_req, query_req, base_tick} = 7'h00;
    {mgmt_mode_active, headroom_ok, msr_lp, pmc_lp, core_tick, ref_tick} = 8'h00;
    {msr_addr, msr_wdata, pmc_sel, query_leaf} = '0;
    {boost_capable, lp_active, criteria_ok, mismatches, n_compared} = {5'h1F, 64'h0};
    seed = lfsr(32'h6978);
    current_op_point = {seed[31:16], seed[15:0]};
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    mr(0, 0, ADDR_MISC_ENABLE, 0); `CHK(rd[MISC_OPP_DISABLE_BIT], 1'b1)
    qp(1, QUERY_LEAF_POWER); `CHK(query_eax[1], 1'b0)
    `CHK(query_ecx[0], 1'b1)
    qp(1, 32'h0000_0007); `CHK(query_eax, 32'h0)
    headroom_ok <= 1'b1;
    mr(1, 1, ADDR_MISC_ENABLE, 0);
    mr(0, 0, ADDR_MISC_ENABLE, 0); `CHK(rd[MISC_OPP_DISABLE_BIT], 1'b0)
    qp(1, QUERY_LEAF_POWER); `CHK(query_eax[1], 1'b1)
    a = {31'h0, 1'b1, 16'h0, seed[15:0]};
    mr(0, 1, ADDR_PERF_CTL, a);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(boost_eligible, 2'b10)
    `CHK(boost_engaged, 2'b10)
    mr(0, 0, ADDR_PERF_CTL, 0); `CHK(rd, a)
    mr(0, 0, ADDR_PERF_STATUS, 0); `CHK({rd[32], rd[15:0]}, {1'b0, current_op_point[0]})
    mr(0, 1, ADDR_PERF_CTL, {a[63:33], 1'b0, a[31:0]});
    mr(0, 1, ADDR_PERF_STATUS, 1); `CHK(f, 1'b1)
    mr(0, 0, 32'h0000_0500, 0); `CHK({f, rd}, 65'h1_0000_0000_0000_0000)
    #1 `CHK(boost_eligible, 2'b11)
    `CHK(target_op_point[0], a[15:0])
    criteria_ok <= 2'b01;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(boost_engaged, 2'b01)
    headroom_ok <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(boost_engaged, 2'b00)
    mr(0, 1, ADDR_MISC_ENABLE, 64'h40_0000_0000);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(boost_eligible, 2'b00)
    qp(1, QUERY_LEAF_POWER); `CHK(query_eax[1], 1'b0)
    mr(0, 1, ADDR_ACTUAL_PERF, '1);
    mr(0, 1, ADDR_FIXED_RATE, 5);
    tk(1, 2'b01, 0);
    mr(0, 0, ADDR_ACTUAL_PERF, 0); `CHK(rd, 64'h0)
    mr(0, 0, ADDR_FIXED_RATE, 0); `CHK(rd, 64'h0)
    qp(0, PMC_SEL_CORE); b = pmc_data;
    mr(0, 0, ADDR_REF_TICK, 0); a = rd;
    seed = lfsr(seed);
    n = 64'(seed[2:0]) + 64'h1;
    tk(int'(n), 2'b11, 0);
    mr(0, 0, ADDR_ACTUAL_PERF, 0); `CHK(rd, n)
    mr(0, 0, ADDR_FIXED_RATE, 0); `CHK(rd, n)
    qp(0, PMC_SEL_CORE); `CHK(pmc_data, b + n)
    qp(0, PMC_SEL_REF); `CHK(pmc_data, a + n)
    mr(0, 0, ADDR_REF_TICK, 0); `CHK(rd, a + n)
    qp(0, 32'h4000_0003); `CHK(f, 1'b1)
    lp_active <= 2'b10;
    tk(2, 2'b11, 0);
    mr(0, 0, ADDR_ACTUAL_PERF, 0); `CHK(rd, n)
    lp_active <= 2'b11;
    mgmt_mode_active <= 1'b1;
    mr(0, 1, ADDR_MISC_ENABLE, 64'h40_0000_1000);
    mr(0, 0, ADDR_TIMESTAMP, 0); a = rd;
    tk(3, 2'b01, 1);
    mr(0, 0, ADDR_ACTUAL_PERF, 0); `CHK(rd, n)
    mr(0, 0, ADDR_TIMESTAMP, 0); `CHK(rd, a + 64'(BASE_RATIO_DEF) * 3)
    mr(0, 0, ADDR_PLAT_INFO, 0); `CHK(rd[15:8], BASE_RATIO_DEF)
    wrap_up();
  end
endmodule : test_opp_perf_control
